// >>> inc/rtp_trim_regs.vh
`ifndef RTP_TRIM_REGS_VH
`define RTP_TRIM_REGS_VH
// Register addresses
`define RTP_ADDR_HOUR       8'h02
`define RTP_ADDR_WKDAY      8'h03
`define RTP_ADDR_CONTROL    8'h08
`define RTP_ADDR_TRIM       8'h09
`define RTP_ADDR_PDN_BASE   8'h18
`define RTP_ADDR_PUP_BASE   8'h1C
// Field positions
`define RTP_HOUR_DIR_BIT    7
`define RTP_CTL_OUT_BIT     7
`define RTP_CTL_SQW_BIT     6
`define RTP_CTL_COARSE_BIT  2
`define RTP_WKDAY_PFAIL_BIT 4
`define RTP_WKDAY_BKEN_BIT  3
// Reset values
`define RTP_TRIM_RESET      8'h00
`define RTP_CTL_RESET       8'h80
// Timing counts in oscillator cycles; RTP_SECS_PER_MIN counts seconds
`define RTP_CYCLES_PER_SEC  15'h7FFF
`define RTP_SECS_PER_MIN    6'h3B
`define RTP_HALF_SEC        16'h4000
`endif

// >>> design/rtp_prescaler.v
`timescale 1ns/1ps
`include "rtp_trim_regs.vh"
// Divides the oscillator tick to seconds, stretching or shortening the
// second after the one on which a trim event lands.
module rtp_prescaler (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst_n,
   // Control
   input  wire        oscTick,
   input  wire        trimEvent,
   input  wire        trimDirection,
   input  wire [7:0]  trimMagnitude,
   // Status
   output reg         secondPulse,
   output reg         halfPhase
);
   reg  [15:0] count;
   reg  [9:0]  holdCnt;
   wire [9:0]  trimCycles = {1'b0, trimMagnitude, 1'b0};

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count       <= 16'h0000;
         holdCnt     <= 10'h000;
         secondPulse <= 1'b0;
         halfPhase   <= 1'b0;
      end else begin
         secondPulse <= 1'b0;
         if (oscTick) begin
            if (holdCnt != 10'h000) begin
               // Removing cycles: swallow ticks so the second runs long
               holdCnt <= holdCnt - 10'h001;
            end else if (count >= {1'b0, `RTP_CYCLES_PER_SEC}) begin
               count       <= 16'h0000;
               secondPulse <= 1'b1;
               if (trimEvent && trimCycles != 10'h000) begin
                  // Set direction adds cycles: a slow crystal gets a short second
                  if (trimDirection)
                     count <= {6'h00, trimCycles};
                  else
                     holdCnt <= trimCycles;
               end
            end else begin
               count <= count + 16'h0001;
            end
            halfPhase <= (count >= `RTP_HALF_SEC);
         end
      end
   end
endmodule // rtp_prescaler

// >>> design/rtp_stamp_log.v
`timescale 1ns/1ps
`include "rtp_trim_regs.vh"
// Power-down and power-up timestamp sets with power-fail guard.
module rtp_stamp_log (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst_n,
   // Events
   input  wire        captureDown,
   input  wire        captureUp,
   input  wire        clearFlag,
   input  wire [31:0] timeNow,
   // Readout
   input  wire [2:0]  readSel,
   output wire [7:0]  readData,
   output reg         powerFailFlag
);
   reg [7:0] stamp [0:7];
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : gStamp
         always @(posedge core_clk or negedge rst_n) begin
            if (!rst_n)
               stamp[i] <= 8'h00;
            else if (!powerFailFlag && ((i < 4) ? captureDown : captureUp))
               // Capture beats a clear in the same cycle, as the flag does
               stamp[i] <= timeNow[8*(i%4) +: 8];
            else if (clearFlag)
               stamp[i] <= 8'h00;
         end
      end
   endgenerate

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         powerFailFlag <= 1'b0;
      else if (captureUp && !powerFailFlag)
         powerFailFlag <= 1'b1;
      else if (clearFlag)
         powerFailFlag <= 1'b0;
   end

   assign readData = stamp[readSel];
endmodule // rtp_stamp_log

// >>> design/rtp_trim_power.v
`timescale 1ns/1ps
`include "rtp_trim_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module rtp_trim_power (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst_n,
   // Oscillator
   input  wire        oscTick,
   // Register port from the serial engine
   input  wire        regWrite,
   input  wire        regRead,
   input  wire [7:0]  regAddr,
   input  wire [7:0]  regWdata,
   output reg  [7:0]  regRdata,
   // Supply sensing
   input  wire        primaryBelowThreshold,
   // Current calendar (BCD)
   input  wire [7:0]  curMinutes,
   input  wire [6:0]  curHours,
   input  wire [7:0]  curDate,
   input  wire [7:0]  curMonthWkday,
   // Watchdog enable
   input  wire        watchdogEnableWrite,
   input  wire        watchdogEnableIn,
   output reg         watchdogEnable,
   // Outputs
   output wire        secondPulse,
   output wire        onBackup,
   output wire        serialBlocked,
   output wire        eventDetectStop,
   output reg         clockOutputPin,
   output wire        clockOutputEnable
);
   reg  [7:0] trimMagnitude;
   reg        trimDirection;
   reg  [6:0] hourFields;
   reg  [7:0] rtcControl;
   reg        backupInputEnable;
   reg  [5:0] secCount;
   reg        onBackupR;
   reg        onBackupD;
   wire       halfPhase;
   wire       trimEvent;
   wire       powerFailFlag;
   wire [7:0] stampData;
   wire       coarseTrimEnable;
   wire       squareWaveEnable;
   wire       busOk;

   assign coarseTrimEnable = rtcControl[`RTP_CTL_COARSE_BIT];
   assign squareWaveEnable = rtcControl[`RTP_CTL_SQW_BIT];
   assign onBackup         = onBackupR;
   assign busOk            = !onBackupR;
   assign serialBlocked    = onBackupR;
   assign eventDetectStop  = onBackupR;

   function inRange;
      input [7:0] addr;
      input [7:0] base;
      begin
         inRange = (addr[7:2] == base[7:2]);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Supply switchover
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         onBackupR <= 1'b0;
         onBackupD <= 1'b0;
      end else begin
         // Without backup enabled there is nothing to switch to
         onBackupR <= primaryBelowThreshold && backupInputEnable;
         onBackupD <= onBackupR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         trimMagnitude     <= `RTP_TRIM_RESET;
         trimDirection     <= 1'b0;
         hourFields        <= 7'h00;
         rtcControl        <= `RTP_CTL_RESET;
         backupInputEnable <= 1'b0;
      end else if (regWrite && busOk) begin
         case (regAddr)
            `RTP_ADDR_TRIM: trimMagnitude <= regWdata;
            `RTP_ADDR_HOUR: begin
               trimDirection <= regWdata[`RTP_HOUR_DIR_BIT];
               hourFields    <= regWdata[6:0];
            end
            `RTP_ADDR_CONTROL: rtcControl <= regWdata;
            `RTP_ADDR_WKDAY: backupInputEnable <= regWdata[`RTP_WKDAY_BKEN_BIT];
            default: ;
         endcase
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         watchdogEnable <= 1'b0;
      else if (onBackupR && !onBackupD)
         watchdogEnable <= 1'b0;
      else if (watchdogEnableWrite && busOk)
         watchdogEnable <= watchdogEnableIn;
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         regRdata <= 8'h00;
      else if (regRead && busOk) begin
         if (inRange(regAddr, `RTP_ADDR_PDN_BASE) || inRange(regAddr, `RTP_ADDR_PUP_BASE))
            regRdata <= stampData;
         else
            case (regAddr)
               `RTP_ADDR_TRIM:    regRdata <= trimMagnitude;
               `RTP_ADDR_HOUR:    regRdata <= {trimDirection, hourFields};
               `RTP_ADDR_CONTROL: regRdata <= rtcControl;
               `RTP_ADDR_WKDAY:   regRdata <= {3'h0, powerFailFlag, backupInputEnable, 3'h0};
               default:           regRdata <= 8'h00;
            endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trim scheduling; runs regardless of supply
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         secCount <= 6'h00;
      else if (secondPulse)
         secCount <= (secCount >= `RTP_SECS_PER_MIN) ? 6'h00 : secCount + 6'h01;
   end

   // Fine mode trims on the minute, coarse on every second
   assign trimEvent = coarseTrimEnable || (secCount == `RTP_SECS_PER_MIN);

   rtp_prescaler uPrescaler (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .oscTick       (oscTick),
      .trimEvent     (trimEvent),
      .trimDirection (trimDirection),
      .trimMagnitude (trimMagnitude),
      .secondPulse   (secondPulse),
      .halfPhase     (halfPhase)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Timestamp capture on both switchover edges
   rtp_stamp_log uStamp (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .captureDown   (onBackupR && !onBackupD),
      .captureUp     (!onBackupR && onBackupD),
      .clearFlag     (regWrite && busOk && regAddr == `RTP_ADDR_WKDAY &&
                      !regWdata[`RTP_WKDAY_PFAIL_BIT]),
      .timeNow       ({curMonthWkday, curDate, 1'b0, curHours, curMinutes}),
      .readSel       ({regAddr[2], regAddr[1:0]}),
      .readData      (stampData),
      .powerFailFlag (powerFailFlag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Trimmed 1 Hz output with square wave and coarse trim both enabled; pin released on backup
   assign clockOutputEnable = !onBackupR;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         clockOutputPin <= 1'b0;
      else if (onBackupR)
         clockOutputPin <= 1'b0;
      else if (squareWaveEnable && coarseTrimEnable)
         clockOutputPin <= halfPhase;
      else
         clockOutputPin <= rtcControl[`RTP_CTL_OUT_BIT] && !squareWaveEnable;
   end
endmodule // rtp_trim_power

// >>> dv/rtp_supply_model.sv
`timescale 1ns/1ps
// Crystal and primary supply seen from the block; ticks every core cycle
module rtp_supply_model (
   // Clock and reset
   input  wire core_clk,
   input  wire rst_n,
   // Control from the bench
   input  wire failReq,
   // Outputs
   output reg  oscTick,
   output reg  primaryBelowThreshold
);
   // Oscillator runs from reset release, before backup is enabled
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         oscTick               <= 1'b0;
         primaryBelowThreshold <= 1'b0;
      end else begin
         oscTick               <= 1'b1;
         primaryBelowThreshold <= failReq;
      end
   end
endmodule // rtp_supply_model

// >>> dv/rtp_trim_power_checker.sv
`timescale 1ns/1ps
module rtp_trim_power_checker (
   // Clock and reset
   input wire       core_clk,
   input wire       rst_n,
   // Observed ports
   input wire       regRead,
   input wire [7:0] regRdata,
   input wire       primaryBelowThreshold,
   input wire       watchdogEnableWrite,
   input wire       watchdogEnableIn,
   input wire       watchdogEnable,
   input wire       secondPulse,
   input wire       onBackup,
   input wire       serialBlocked,
   input wire       eventDetectStop,
   input wire       clockOutputPin,
   input wire       clockOutputEnable
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_blk; serialBlocked == onBackup && eventDetectStop == onBackup; endproperty
   property p_oe; clockOutputEnable == !onBackup; endproperty
   property p_wdoff; $rose(onBackup) |-> ##[0:2] !watchdogEnable; endproperty
   property p_wdon;
      $rose(watchdogEnable) |-> $past(watchdogEnableWrite) && $past(watchdogEnableIn);
   endproperty
   property p_dn; $rose(onBackup) |-> $past(primaryBelowThreshold); endproperty
   property p_up; $fell(onBackup) |-> !$past(primaryBelowThreshold); endproperty
   property p_sec; secondPulse |=> !secondPulse [*8]; endproperty
   property p_rdbk; regRead && onBackup |=> $stable(regRdata); endproperty
   a_blk: assert property (p_blk) else $error("gating differs from backup state");
   a_oe: assert property (p_oe) else $error("clock pin enabled on backup");
   a_wdoff: assert property (p_wdoff) else $error("watchdog kept on backup");
   a_wdon: assert property (p_wdon) else $error("watchdog set without write");
   a_dn: assert property (p_dn) else $error("switch to backup without trip");
   a_up: assert property (p_up) else $error("return to primary while low");
   a_sec: assert property (p_sec) else $error("second pulse too close");
   a_rdbk: assert property (p_rdbk) else $error("read served on backup");
   c_bk: cover property ($rose(onBackup));
   c_sec: cover property (secondPulse);
   c_pin: cover property ($rose(clockOutputPin) && clockOutputEnable);
endmodule // rtp_trim_power_checker
bind rtp_trim_power rtp_trim_power_checker i_rtp_trim_power_checker (.core_clk, .rst_n,
   .regRead, .regRdata, .primaryBelowThreshold, .watchdogEnableWrite, .watchdogEnableIn,
   .watchdogEnable, .secondPulse, .onBackup, .serialBlocked, .eventDetectStop,
   .clockOutputPin, .clockOutputEnable);

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg         core_clk, rst_n, regWrite, regRead, failReq, wdW, wdIn;
   reg  [7:0]  regAddr, regWdata, curMinutes, curDate, curMonthWkday, rdv;
   reg  [6:0]  curHours;
   reg  [7:0]  expv [0:7];
   wire [7:0]  regRdata;
   wire        oscTick, primaryBelowThreshold, watchdogEnable, secondPulse, onBackup;
   wire        serialBlocked, eventDetectStop, clockOutputPin, clockOutputEnable;
   integer     n_mismatch, total_checks, cyc, i, n, e;
   reg         pinLast;
   rtp_supply_model i_rtp_supply_model (.core_clk, .rst_n, .failReq, .oscTick,
      .primaryBelowThreshold);
   rtp_trim_power i_rtp_trim_power (.core_clk, .rst_n, .oscTick, .regWrite, .regRead,
      .regAddr, .regWdata, .regRdata, .primaryBelowThreshold, .curMinutes, .curHours,
      .curDate, .curMonthWkday, .watchdogEnableWrite(wdW), .watchdogEnableIn(wdIn),
      .watchdogEnable, .secondPulse, .onBackup, .serialBlocked, .eventDetectStop,
      .clockOutputPin, .clockOutputEnable);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task chk(input [15:0] g, input [15:0] x);
      total_checks = total_checks + 1;
      if (g !== x) begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge core_clk); #1 regWrite = 1'b1; regAddr = a; regWdata = d;
      @(posedge core_clk); #1 regWrite = 1'b0;
   endtask
   // Read data is checked one edge late, it stands until the next read
   task rd(input [7:0] a);
      @(posedge core_clk); #1 regRead = 1'b1; regAddr = a;
      @(posedge core_clk); #1 regRead = 1'b0;
      @(posedge core_clk); #1 rdv = regRdata;
   endtask
   // Supply changes pass the model's register, so allow a few edges
   task supply(input f);
      failReq = f;
      repeat (6) @(posedge core_clk);
      #1;
   endtask
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 80000) begin
         n_mismatch = n_mismatch + 1;
         print_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {regWrite, regRead, failReq, wdW, wdIn, regAddr, regWdata} = 0;
      {curMinutes, curHours, curDate, curMonthWkday} = 0;
      {n_mismatch, total_checks, cyc, rst_n} = 0;
      repeat (4) @(posedge core_clk);
      #1 rst_n = 1'b1;
      rd(8'h09); chk(rdv, 8'h00);
      wr(8'h09, 8'h00);
      wr(8'h09, 8'h80);
      rd(8'h09); chk(rdv, 8'h80);
      wr(8'h02, 8'h80);
      wr(8'h08, 8'h47);
      supply(1'b1); chk(onBackup, 1'b0);
      supply(1'b0);
      wr(8'h03, 8'h08);
      @(posedge core_clk); #1 wdW = 1'b1; wdIn = 1'b1;
      @(posedge core_clk); #1 wdW = 1'b0;
      @(posedge core_clk); #1 chk(watchdogEnable, 1'b1);
      {curMinutes, curHours, curDate, curMonthWkday} = {8'h45, 7'h23, 8'h31, 8'hF2};
      supply(1'b1); chk(onBackup, 1'b1);
      chk(watchdogEnable, 1'b0);
      chk({clockOutputEnable, clockOutputPin, serialBlocked, eventDetectStop}, 4'h3);
      rd(8'h1F); chk(rdv, 8'h80);
      {curMinutes, curHours, curDate, curMonthWkday} = {8'h07, 7'h06, 8'h01, 8'h23};
      supply(1'b0); chk({onBackup, watchdogEnable}, 2'b00);
      {expv[0], expv[1], expv[2], expv[3]} = {8'h45, 8'h23, 8'h31, 8'hF2};
      {expv[4], expv[5], expv[6], expv[7]} = {8'h07, 8'h06, 8'h01, 8'h23};
      for (i = 0; i < 8; i = i + 1) begin
         rd(8'h18 + i[7:0]); chk(rdv, expv[i]);
      end
      rd(8'h03); chk(rdv[4], 1'b1);
      curMinutes = 8'h59;
      supply(1'b1);
      supply(1'b0);
      rd(8'h18); chk(rdv, 8'h45);
      wr(8'h03, 8'h08);
      for (i = 0; i < 8; i = i + 1) begin
         rd(8'h18 + i[7:0]); chk(rdv, 8'h00);
      end
      rd(8'h03); chk(rdv[4], 1'b0);
      // Coarse mode, direction set adds cycles: each second lasts 32768 - 2 * 0x80 ticks
      while (secondPulse !== 1'b1) begin
         @(posedge core_clk);
         #1;
      end
      n = 0;
      e = 0;
      pinLast = clockOutputPin;
      do begin
         @(posedge core_clk);
         #1;
         n = n + 1;
         if (clockOutputPin !== pinLast) e = e + 1;
         pinLast = clockOutputPin;
      end while (secondPulse !== 1'b1);
      chk(n[15:0], 16'h7F00);
      chk(e[15:0], 16'h0002);
      print_verdict;
   end
endmodule // testbench
